// file: verilog/pcm_regs.sv
// pcm_regs: axi4-lite register block of the power and clock manager.
// assumes a synchronous active-low reset and inputs synchronous to aclk.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - core enable write-one starts core clock
// - core disable write-one stops core clock
// - core state reads running, resets one
// - peripheral enable write-one starts clocks
// - peripheral disable write-one stops clocks
// - peripheral state shows running clocks
// - bypass bit selects external clock input
// - oscillator enable bit runs oscillator
// - output disable bit tri-states clock pin
// - prescaler divides by powers of two
// - pll factor zero powers pll down
// - clock source selects slow, osc, pll
// - osc counter preloads, ticks slow/8
// - pll counter preloads on factor change
// - shutdown command drives selected pin state
// - wake command drives pin, wins tie
// - forbidden clock source writes are ignored
// - stable flag set when counter reaches zero
module pcm_regs #(
  parameter int slow_cycles = pcm_pkg::pcm_slow_cycles
) (
  // system
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // clock controls
  output logic             core_clk_en,
  output logic [31:0]      periph_clk_en,
  output logic             osc_enable,
  output logic             osc_bypass,
  output logic [5:0]       pll_factor,
  output logic [1:0]       clk_source,
  output logic [2:0]       prescaler_sel,
  output logic             master_clock_en,
  output logic             clk_out_pin_o,
  output logic             clk_out_pin_oe,
  output logic             shutdown_pin_o,
  output logic             shutdown_pin_oe
);

  // write channel: address and data held until both present
  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic        awready_q;
  logic        wready_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;

  // block state
  logic        core_q;
  logic [31:0] per_q;
  logic [31:0] cg_q;
  logic [7:0]  pmode_q;
  logic [1:0]  imask_q;
  logic [7:0]  osc_cnt_q;
  logic        osc_counting_q;
  logic        osc_stable_q;
  logic [5:0]  pll_cnt_q;
  logic        pll_counting_q;
  logic        pll_locked_q;
  logic [1:0]  shd_state_q;
  logic [15:0] slow_div_q;
  logic        slow_tick_q;
  logic [2:0]  osc_div_q;
  logic [6:0]  prescaler_sel_cnt_q;
  logic        mck_en_q;
  logic        clk_out_q;
  logic        clk_out_oe_q;
  logic        shd_o_q;
  logic        shd_oe_q;

  wire         wr_fire   = aw_have_q && w_have_q && !bvalid_q;
  wire         wr_full   = (w_strb_q == 4'hf);
  wire [31:0]  wd        = w_data_q;
  wire         wr_core_en  = wr_fire && aw_addr_q == pcm_pkg::pcm_off_core_en;
  wire         wr_core_dis = wr_fire && aw_addr_q == pcm_pkg::pcm_off_core_dis;
  wire         wr_per_en   = wr_fire && aw_addr_q == pcm_pkg::pcm_off_per_en;
  wire         wr_per_dis  = wr_fire && aw_addr_q == pcm_pkg::pcm_off_per_dis;
  wire         wr_cg       = wr_fire && aw_addr_q == pcm_pkg::pcm_off_cgmode && wr_full;
  wire         wr_cmd      = wr_fire && aw_addr_q == pcm_pkg::pcm_off_pwr_cmd;
  wire         wr_pmode    = wr_fire && aw_addr_q == pcm_pkg::pcm_off_pwr_mode;
  wire         wr_irq_en   = wr_fire && aw_addr_q == pcm_pkg::pcm_off_irq_en;
  wire         wr_irq_dis  = wr_fire && aw_addr_q == pcm_pkg::pcm_off_irq_dis;

  // candidate mode word and its fields
  wire [31:0]  cg_new     = wd & pcm_pkg::pcm_cgmode_mask;
  wire         new_osc_en = cg_new[pcm_pkg::pcm_bit_osc_en];
  wire [2:0]   new_prescaler_sel   = cg_new[pcm_pkg::pcm_prescaler_sel_lsb +: 3];
  wire [5:0]   new_mul    = cg_new[pcm_pkg::pcm_mul_lsb +: 6];
  wire [1:0]   new_css    = cg_new[pcm_pkg::pcm_css_lsb +: 2];
  wire [7:0]   new_oscnt  = cg_new[pcm_pkg::pcm_oscnt_lsb +: 8];
  wire [5:0]   new_pllcnt = cg_new[pcm_pkg::pcm_pllcnt_lsb +: 6];
  wire [1:0]   cur_css    = cg_q[pcm_pkg::pcm_css_lsb +: 2];
  wire         cur_osc_en = cg_q[pcm_pkg::pcm_bit_osc_en];
  wire [5:0]   cur_mul    = cg_q[pcm_pkg::pcm_mul_lsb +: 6];

  // forbidden combinations keep the old word
  wire cg_rsvd    = (new_prescaler_sel == pcm_pkg::pcm_prescaler_sel_rsvd) ||
                    (new_css == pcm_pkg::pcm_css_rsvd);
  wire leave_slow = (new_css != pcm_pkg::pcm_css_slow) && !(cur_osc_en && osc_stable_q && new_osc_en);
  wire pll_kill   = (new_mul == 6'h00) && (cur_css == pcm_pkg::pcm_css_pll || new_css == pcm_pkg::pcm_css_pll);
  wire osc_kill   = !new_osc_en && (cur_css != pcm_pkg::pcm_css_slow || new_css != pcm_pkg::pcm_css_slow);
  wire cg_ok      = wr_cg && !cg_rsvd && !leave_slow && !pll_kill && !osc_kill;
  wire osc_load   = cg_ok && new_osc_en && !cur_osc_en && new_oscnt != 8'h00;
  wire pll_load   = cg_ok && new_mul != cur_mul && new_mul != 6'h00 && new_pllcnt != 6'h00;
  wire osc_tick   = slow_tick_q && osc_div_q == 3'(pcm_pkg::pcm_osc_tick_div - 1);

  // axi write handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      awready_q <= !aw_have_q && !awready_q && s_awvalid;
      wready_q  <= !w_have_q && !wready_q && s_wvalid;
      if (s_awvalid && awready_q)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_awaddr[7:2], 2'b00};
      end
      if (s_wvalid && wready_q)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
      end
      else if (bvalid_q && s_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read data mux; write-only and reserved offsets read zero
  logic [31:0] rd_mux;
  always_comb
  begin
    case ({s_araddr[7:2], 2'b00})
      pcm_pkg::pcm_off_core_state: rd_mux = {31'h0, core_q};
      pcm_pkg::pcm_off_per_state:  rd_mux = per_q;
      pcm_pkg::pcm_off_cgmode:     rd_mux = cg_q;
      pcm_pkg::pcm_off_pwr_mode:   rd_mux = {24'h0, pmode_q};
      pcm_pkg::pcm_off_cg_state:   rd_mux = {30'h0, pll_locked_q, osc_stable_q};
      pcm_pkg::pcm_off_irq_mask:   rd_mux = {30'h0, imask_q};
      default:                     rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      arready_q <= !rvalid_q && !arready_q && s_arvalid;
      if (s_arvalid && arready_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
      end
      else if (rvalid_q && s_rready)
        rvalid_q <= 1'b0;
    end
  end

  // clock gating and configuration state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_q  <= pcm_pkg::pcm_core_rst;
      per_q   <= pcm_pkg::pcm_per_rst;
      cg_q    <= pcm_pkg::pcm_cgmode_rst;
      pmode_q <= pcm_pkg::pcm_pwr_mode_rst;
      imask_q <= pcm_pkg::pcm_irq_mask_rst;
    end
    else
    begin
      if (wr_core_dis && wd[0])
        core_q <= 1'b0;
      else if (wr_core_en && wd[0])
        core_q <= 1'b1;
      if (wr_per_en)
        per_q <= per_q | (wd & pcm_pkg::pcm_per_valid);
      if (wr_per_dis)
        per_q <= per_q & ~(wd & pcm_pkg::pcm_per_valid);
      if (cg_ok)
        cg_q <= cg_new;
      if (wr_pmode)
        pmode_q <= wd[7:0];
      if (wr_irq_en)
        imask_q <= imask_q | wd[1:0];
      if (wr_irq_dis)
        imask_q <= imask_q & ~wd[1:0];
    end
  end

  // slow clock tick and start-up counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_div_q     <= 16'h0000;
      slow_tick_q    <= 1'b0;
      osc_div_q      <= 3'h0;
      osc_cnt_q      <= 8'h00;
      osc_counting_q <= 1'b0;
      osc_stable_q   <= 1'b0;
      pll_cnt_q      <= 6'h00;
      pll_counting_q <= 1'b0;
      pll_locked_q   <= 1'b0;
    end
    else
    begin
      slow_tick_q <= slow_div_q == 16'(slow_cycles - 1);
      slow_div_q  <= (slow_div_q == 16'(slow_cycles - 1)) ? 16'h0000 : slow_div_q + 16'h0001;
      if (slow_tick_q)
        osc_div_q <= osc_div_q + 3'h1;
      if (!cg_q[pcm_pkg::pcm_bit_osc_en])
      begin
        osc_stable_q   <= 1'b0;
        osc_counting_q <= 1'b0;
      end
      if (osc_load)
      begin
        osc_cnt_q      <= new_oscnt;
        osc_counting_q <= 1'b1;
        osc_stable_q   <= 1'b0;
      end
      else if (osc_counting_q && osc_tick)
      begin
        osc_cnt_q <= osc_cnt_q - 8'h01;
        if (osc_cnt_q == 8'h01)
        begin
          osc_counting_q <= 1'b0;
          osc_stable_q   <= 1'b1;
        end
      end
      else if (cg_q[pcm_pkg::pcm_bit_osc_en] && !osc_counting_q && osc_cnt_q == 8'h00)
        osc_stable_q <= 1'b1;
      if (cur_mul == 6'h00 || !osc_stable_q)
      begin
        pll_locked_q   <= 1'b0;
        pll_counting_q <= 1'b0;
      end
      if (pll_load)
      begin
        pll_cnt_q      <= new_pllcnt;
        pll_counting_q <= 1'b1;
        pll_locked_q   <= 1'b0;
      end
      else if (pll_counting_q && slow_tick_q)
      begin
        pll_cnt_q <= pll_cnt_q - 6'h01;
        if (pll_cnt_q == 6'h01)
        begin
          pll_counting_q <= 1'b0;
          pll_locked_q   <= osc_stable_q;
        end
      end
    end
  end

  // master clock enable: prescaler divides selected source tick
  wire       src_tick = (cur_css == pcm_pkg::pcm_css_slow) ? slow_tick_q : 1'b1;
  wire [6:0] prescaler_sel_lim = 7'((1 << cg_q[pcm_pkg::pcm_prescaler_sel_lsb +: 3]) - 1);

  // shut-down pin: wake command wins over shut-down
  wire       do_wake = wr_cmd && wd[1];
  wire       do_shd  = wr_cmd && wd[0] && !wd[1];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prescaler_sel_cnt_q   <= 7'h00;
      mck_en_q     <= 1'b0;
      clk_out_q    <= 1'b0;
      clk_out_oe_q <= 1'b0;
      shd_state_q  <= pcm_pkg::pcm_pin_tris;
      shd_o_q      <= 1'b0;
      shd_oe_q     <= 1'b0;
    end
    else
    begin
      mck_en_q <= 1'b0;
      if (src_tick)
      begin
        prescaler_sel_cnt_q <= (prescaler_sel_cnt_q >= prescaler_sel_lim) ? 7'h00 : prescaler_sel_cnt_q + 7'h01;
        mck_en_q   <= prescaler_sel_cnt_q >= prescaler_sel_lim;
      end
      if (mck_en_q)
        clk_out_q <= ~clk_out_q;
      clk_out_oe_q <= !cg_q[pcm_pkg::pcm_bit_clkout_d];
      if (do_wake)
        shd_state_q <= pmode_q[3:2];
      else if (do_shd)
        shd_state_q <= pmode_q[1:0];
      shd_oe_q <= shd_state_q == pcm_pkg::pcm_pin_low || shd_state_q == pcm_pkg::pcm_pin_high;
      shd_o_q  <= shd_state_q == pcm_pkg::pcm_pin_high;
    end
  end

  assign s_awready       = awready_q;
  assign s_wready        = wready_q;
  assign s_bvalid        = bvalid_q;
  assign s_bresp         = pcm_pkg::pcm_resp_okay;
  assign s_arready       = arready_q;
  assign s_rvalid        = rvalid_q;
  assign s_rdata         = rdata_q;
  assign s_rresp         = pcm_pkg::pcm_resp_okay;
  assign core_clk_en     = core_q;
  assign periph_clk_en   = per_q;
  assign osc_enable      = cg_q[pcm_pkg::pcm_bit_osc_en];
  assign osc_bypass      = cg_q[pcm_pkg::pcm_bit_bypass];
  assign pll_factor      = cur_mul;
  assign clk_source      = cur_css;
  assign prescaler_sel   = cg_q[pcm_pkg::pcm_prescaler_sel_lsb +: 3];
  assign master_clock_en = mck_en_q;
  assign clk_out_pin_o   = clk_out_q;
  assign clk_out_pin_oe  = clk_out_oe_q;
  assign shutdown_pin_o  = shd_o_q;
  assign shutdown_pin_oe = shd_oe_q;

  // assertions
  chk_core_enable: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_core_en && wd[0] && !wr_core_dis |=> core_q) else $error("core clock not enabled");
  chk_core_disable: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_core_dis && wd[0] |=> !core_q) else $error("core clock not disabled");
  chk_per_set: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_per_en |=> (per_q & ($past(wd) & pcm_pkg::pcm_per_valid)) == ($past(wd) & pcm_pkg::pcm_per_valid))
    else $error("peripheral clock not enabled");
  chk_per_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_per_dis |=> (per_q & $past(wd)) == 32'h0) else $error("peripheral clock not disabled");
  chk_cg_forbid: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cg && (cg_rsvd || pll_kill || osc_kill) |=> $stable(cg_q)) else $error("forbidden write took");
  chk_prescaler_sel_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
    cg_q[pcm_pkg::pcm_prescaler_sel_lsb +: 3] != pcm_pkg::pcm_prescaler_sel_rsvd) else $error("reserved prescaler");
  chk_osc_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    osc_stable_q |-> cg_q[pcm_pkg::pcm_bit_osc_en] || $past(cg_q[pcm_pkg::pcm_bit_osc_en]))
    else $error("stable without oscillator");
  chk_wake_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wake |=> shd_state_q == $past(pmode_q[3:2])) else $error("wake command lost");
  chk_shd_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    do_shd |=> shd_state_q == $past(pmode_q[1:0])) else $error("shutdown command lost");
  chk_clkout_dis: assert property (@(posedge aclk) disable iff (!aresetn)
    cg_q[pcm_pkg::pcm_bit_clkout_d] [*2] |-> !clk_out_oe_q) else $error("clock pin driven");

endmodule

`default_nettype wire

// file: verilog/pcm_pkg.sv
// pcm_pkg: register map, field layout and timing constants of the power and clock manager.
// assumes a single 100 MHz system clock; the slow clock is derived from it by a divider.
package pcm_pkg;

  // register byte offsets
  localparam logic [7:0] pcm_off_core_en    = 8'h00;
  localparam logic [7:0] pcm_off_core_dis   = 8'h04;
  localparam logic [7:0] pcm_off_core_state = 8'h08;
  localparam logic [7:0] pcm_off_per_en     = 8'h10;
  localparam logic [7:0] pcm_off_per_dis    = 8'h14;
  localparam logic [7:0] pcm_off_per_state  = 8'h18;
  localparam logic [7:0] pcm_off_cgmode     = 8'h20;
  localparam logic [7:0] pcm_off_pwr_cmd    = 8'h28;
  localparam logic [7:0] pcm_off_pwr_mode   = 8'h2c;
  localparam logic [7:0] pcm_off_cg_state   = 8'h30;
  localparam logic [7:0] pcm_off_irq_en     = 8'h34;
  localparam logic [7:0] pcm_off_irq_dis    = 8'h38;
  localparam logic [7:0] pcm_off_irq_mask   = 8'h3c;

  // reset values
  localparam logic        pcm_core_rst     = 1'b1;
  localparam logic [31:0] pcm_per_rst      = 32'h0000_0000;
  localparam logic [31:0] pcm_cgmode_rst   = 32'h0000_0000;
  localparam logic [7:0]  pcm_pwr_mode_rst = 8'h01;
  localparam logic [1:0]  pcm_irq_mask_rst = 2'h0;

  // implemented peripheral clock bits: 2-11 and 13-18
  localparam logic [31:0] pcm_per_valid    = 32'h0007_effc;

  // clock generator mode field positions
  localparam int pcm_bit_bypass   = 0;
  localparam int pcm_bit_osc_en   = 1;
  localparam int pcm_bit_clkout_d = 2;
  localparam int pcm_prescaler_sel_lsb     = 4;
  localparam int pcm_mul_lsb      = 8;
  localparam int pcm_css_lsb      = 14;
  localparam int pcm_oscnt_lsb    = 16;
  localparam int pcm_pllcnt_lsb   = 24;
  localparam logic [31:0] pcm_cgmode_mask = 32'h3fff_ff77;

  localparam logic [2:0] pcm_prescaler_sel_rsvd = 3'h7;

  typedef enum logic [1:0] {
    pcm_css_slow = 2'h0,
    pcm_css_osc  = 2'h1,
    pcm_css_pll  = 2'h2,
    pcm_css_rsvd = 2'h3
  } pcm_css_type;

  // shut-down pin selection codes
  localparam logic [1:0] pcm_pin_tris = 2'h0;
  localparam logic [1:0] pcm_pin_low  = 2'h1;
  localparam logic [1:0] pcm_pin_high = 2'h2;

  // timing
  localparam int pcm_clk_mhz      = 100;
  localparam int pcm_slow_hz      = 32768;
  localparam int pcm_slow_cycles  = (pcm_clk_mhz * 1000000) / pcm_slow_hz;
  localparam int pcm_osc_tick_div = 8;

  // axi responses
  localparam logic [1:0] pcm_resp_okay = 2'h0;

  typedef struct packed {
    logic        osc_stable;
    logic        pll_locked;
  } pcm_status_type;

endpackage

// file: tb/pcm_clk_sink.sv
// pcm_clk_sink: far-side model of the master clock consumer and the shut-down pad.
// assumes no pull on the pad; an undriven pad shows the inverse of its last driven level.
`timescale 1ns/1ps
`default_nettype none
module pcm_clk_sink (
  // clock and strobe
  input  wire logic aclk,
  input  wire logic master_clock_en,
  // pad drivers
  input  wire logic shutdown_pin_o,
  input  wire logic shutdown_pin_oe,
  // observations
  output var  int   mck_gap,
  output logic      shutdown_pin_pad
);
  int   gap_cnt = 1;
  logic last_q  = 1'b0;
  always_ff @(posedge aclk)
  begin
    gap_cnt <= master_clock_en ? 1 : gap_cnt + 1;
    if (master_clock_en)
      mck_gap <= gap_cnt;
    if (shutdown_pin_oe)
      last_q <= shutdown_pin_o;
  end
  // floating pad shows a wrong level rather than a lucky one
  assign shutdown_pin_pad = shutdown_pin_oe ? shutdown_pin_o : ~last_q;
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// tb_top: self-checking bench for pcm_regs over axi4-lite against a register model.
// assumes slow_cycles cut to 4 so start-up and lock counts end within a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int slow = 4;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_awaddr = 8'h00;
  logic [7:0]  s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'h0;
  logic        s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, clk_source;
  logic [31:0] s_rdata, periph_clk_en, rd;
  logic        core_clk_en, osc_enable, osc_bypass, master_clock_en, clk_out_pin_o, clk_out_pin_oe;
  logic        shutdown_pin_o, shutdown_pin_oe, shutdown_pin_pad;
  logic [5:0]  pll_factor;
  logic [2:0]  prescaler_sel;
  logic        co;
  int          mck_gap;
  int          error_cnt = 0;
  int          checked = 0;
  logic [31:0] seed = 32'hcfb84613;
  logic        m_core = 1'b1;
  logic [31:0] m_per = 32'h0;
  logic [31:0] m_cg = 32'h0;
  logic [7:0]  m_pm = 8'h01;
  logic [1:0]  m_irq = 2'h0;
  logic        m_stable = 1'b0;
  logic        m_oe = 1'b0;
  logic        m_o = 1'b0;
  logic [7:0]  junk [4] = '{8'h0c, 8'h1c, 8'h24, 8'h40};
  logic [9:0]  sdt [7] = '{10'h024, 10'h025, 10'h026, 10'h025, 10'h027, 10'h00b, 10'h009};

  always #5 aclk = ~aclk;

  pcm_regs #(.slow_cycles(slow)) pcm_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .osc_bypass(osc_bypass), .pll_factor(pll_factor), .clk_source(clk_source),
    .prescaler_sel(prescaler_sel), .master_clock_en(master_clock_en),
    .clk_out_pin_o(clk_out_pin_o), .clk_out_pin_oe(clk_out_pin_oe),
    .shutdown_pin_o(shutdown_pin_o), .shutdown_pin_oe(shutdown_pin_oe));

  pcm_clk_sink pcm_clk_sink_inst (
    .aclk(aclk), .master_clock_en(master_clock_en), .shutdown_pin_o(shutdown_pin_o),
    .shutdown_pin_oe(shutdown_pin_oe), .mck_gap(mck_gap), .shutdown_pin_pad(shutdown_pin_pad));

  task automatic tally_and_finish();
    $display("mismatches %0d of %0d comparisons", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // whole write dropped when it is reserved or forbidden
  function automatic logic [31:0] cg_next(input logic [31:0] o, input logic [31:0] n);
    if (n[6:4] == 3'h7 || n[15:14] == 2'h3)
      return o;
    if ((n[15:14] != 2'h0 && (!m_stable || !o[1] || !n[1])) || (o[15:14] != 2'h0 && !n[1]))
      return o;
    if (n[13:8] == 6'h0 && (n[15:14] == 2'h2 || o[15:14] == 2'h2))
      return o;
    return n;
  endfunction

  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    case (a)
      pcm_pkg::pcm_off_core_en:  m_core = m_core | d[0];
      pcm_pkg::pcm_off_core_dis: m_core = m_core & ~d[0];
      pcm_pkg::pcm_off_per_en:   m_per = m_per | (d & pcm_pkg::pcm_per_valid);
      pcm_pkg::pcm_off_per_dis:  m_per = m_per & ~d;
      pcm_pkg::pcm_off_cgmode:   m_cg = cg_next(m_cg, d & pcm_pkg::pcm_cgmode_mask);
      pcm_pkg::pcm_off_pwr_mode: m_pm = d[7:0];
      pcm_pkg::pcm_off_irq_en:   m_irq = m_irq | d[1:0];
      pcm_pkg::pcm_off_irq_dis:  m_irq = m_irq & ~d[1:0];
      default:                   m_irq = m_irq;
    endcase
  endtask

  function automatic logic [31:0] mread(input logic [7:0] a);
    case (a)
      pcm_pkg::pcm_off_core_state: return {31'h0, m_core};
      pcm_pkg::pcm_off_per_state:  return m_per;
      pcm_pkg::pcm_off_cgmode:     return m_cg;
      pcm_pkg::pcm_off_pwr_mode:   return {24'h0, m_pm};
      pcm_pkg::pcm_off_irq_mask:   return {30'h0, m_irq};
      default:                     return 32'h0;
    endcase
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awready === 1'b1)
        s_awvalid <= 1'b0;
      if (s_wready === 1'b1)
        s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    chk({30'h0, s_bresp}, {30'h0, pcm_pkg::pcm_resp_okay});
    mwr(a, d);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arready === 1'b1)
        s_arvalid <= 1'b0;
    end
    while (s_rvalid !== 1'b1);
    rd = s_rdata;
    s_rready <= 1'b0;
    chk({30'h0, s_rresp}, {30'h0, pcm_pkg::pcm_resp_okay});
  endtask

  task automatic rd_chk(input logic [7:0] a);
    axi_rd(a);
    chk(rd, mread(a));
  endtask

  task automatic st_chk(input logic [1:0] mask, input logic [1:0] exp);
    axi_rd(pcm_pkg::pcm_off_cg_state);
    chk({30'h0, rd[1:0] & mask}, {30'h0, exp});
  endtask

  task automatic cg_step(input logic [31:0] d);
    axi_wr(pcm_pkg::pcm_off_cgmode, d);
    rd_chk(pcm_pkg::pcm_off_cgmode);
    chk({18'h0, m_cg[1:0], ~m_cg[2], m_cg[13:8], m_cg[15:14], m_cg[6:4]},
        {18'h0, osc_enable, osc_bypass, clk_out_pin_oe, pll_factor, clk_source, prescaler_sel});
  endtask

  task automatic sd_step(input logic [9:0] e);
    logic [1:0] sel;
    sel = e[1] ? e[5:4] : e[3:2];
    axi_wr(pcm_pkg::pcm_off_pwr_mode, {24'h0, e[9:2]});
    axi_wr(pcm_pkg::pcm_off_pwr_cmd, {30'h0, e[1:0]});
    if (e[1:0] != 2'h0)
    begin
      m_oe = (sel == pcm_pkg::pcm_pin_low) || (sel == pcm_pkg::pcm_pin_high);
      m_o = (sel == pcm_pkg::pcm_pin_high);
    end
    // pin flops settle one edge after the command lands
    @(posedge aclk);
    chk({30'h0, shutdown_pin_oe, shutdown_pin_pad & m_oe}, {30'h0, m_oe, m_o});
  endtask

  task automatic check_all();
    for (int a = 0; a < 'h40; a += 4)
      if (a != 'h30)
        rd_chk(a[7:0]);
    chk({31'h0, core_clk_en}, {31'h0, m_core});
    chk(periph_clk_en, m_per);
  endtask

  initial
  begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    st_chk(2'h3, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(i[1] ? pcm_pkg::pcm_off_core_en : pcm_pkg::pcm_off_core_dis, {31'h0, i[0]});
      check_all();
    end
    for (int i = 0; i < 12; i++)
    begin
      axi_wr(i[0] ? pcm_pkg::pcm_off_per_dis : pcm_pkg::pcm_off_per_en, rnd());
      rd_chk(pcm_pkg::pcm_off_per_state);
      chk(periph_clk_en, m_per);
    end
    foreach (junk[i])
      axi_wr(junk[i], 32'hffff_ffff);
    axi_wr(pcm_pkg::pcm_off_irq_en, 32'h3);
    axi_wr(pcm_pkg::pcm_off_irq_dis, 32'h1);
    check_all();
    cg_step(32'h0000_0004);
    cg_step(32'h0000_0070);
    cg_step(32'h0000_4000);
    cg_step(32'h0000_c000);
    cg_step(32'h0000_0001);
    cg_step(32'h0002_0002);
    st_chk(2'h1, 2'h0);
    repeat (3 * 8 * slow + 8) @(posedge aclk);
    m_stable = 1'b1;
    st_chk(2'h1, 2'h1);
    for (int p = 0; p < 7; p++)
    begin
      cg_step(32'h0000_4002 | (p << 4));
      repeat ((3 << p) + 40) @(posedge aclk);
      chk(mck_gap, 1 << p);
      co = clk_out_pin_o;
      repeat (1 << p) @(posedge aclk);
      chk({31'h0, clk_out_pin_o}, {31'h0, ~co});
    end
    cg_step(32'h0000_4000);
    cg_step(32'h0800_4302);
    st_chk(2'h2, 2'h0);
    repeat (9 * slow + 8) @(posedge aclk);
    st_chk(2'h2, 2'h2);
    cg_step(32'h0800_8302);
    cg_step(32'h0800_8002);
    cg_step(32'h0000_0002);
    cg_step(32'h0800_4302);
    cg_step(32'h0000_0002);
    cg_step(32'h0000_0000);
    m_stable = 1'b0;
    st_chk(2'h1, 2'h0);
    foreach (sdt[i])
      sd_step(sdt[i]);
    rd_chk(pcm_pkg::pcm_off_pwr_mode);
    tally_and_finish();
  end
endmodule
`default_nettype wire
